// [verilog/gpcp_pkg.sv]
package gpcp_pkg;

  localparam int GPCP_PIN_W = 8;
  localparam int GPCP_ANALOG_W = 5;
  localparam int GPCP_MON_LO = 4;
  localparam int GPCP_MON_HI = 7;
  localparam int GPCP_PULLUP_BIT = 7;
  localparam int GPCP_FLAG_BIT = 0;

  localparam logic [7:0] GPCP_DIR_RST = 8'hff;
  localparam logic [7:0] GPCP_LATCH_RST = 8'h00;
  localparam logic [7:0] GPCP_CAPT_RST = 8'h00;
  localparam logic GPCP_PULLUP_DIS_RST = 1'h1;
  localparam logic [4:0] GPCP_ANALOG_RST = 5'h1f;
  localparam logic GPCP_FLAG_RST = 1'h0;
  localparam logic GPCP_ARMED_RST = 1'h0;

  // Alternate function pin positions
  localparam int GPCP_SER_TX_PIN = 1;
  localparam int GPCP_SER_RX_PIN = 4;
  localparam int GPCP_PWM_PIN0 = 2;
  localparam int GPCP_PWM_PIN1 = 3;
  localparam int GPCP_PWM_PIN2 = 6;
  localparam int GPCP_PWM_PIN3 = 7;
  localparam int GPCP_CONV_PIN0 = 0;
  localparam int GPCP_CONV_PIN1 = 1;
  localparam int GPCP_CONV_PIN2 = 4;

  // One CPU register access, all strobes one cycle wide
  typedef struct packed {
    logic wr_latch;
    logic wr_port;
    logic wr_dir;
    logic wr_ctl2;
    logic wr_analog;
    logic rd_port;
    logic mem_move;
    logic [7:0] data;
  } gpcp_acc_s;

  // Peripheral drive onto the pins
  typedef struct packed {
    logic ser_tx_en;
    logic ser_tx;
    logic [3:0] pwm_en;
    logic [3:0] pwm;
  } gpcp_alt_s;

endpackage

// [verilog/gpcp_sync.sv]
`timescale 1ns/1ps
module gpcp_sync #(
  parameter int WIDTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_stable
);
  logic [WIDTH-1:0] ff1_q;
  logic [WIDTH-1:0] ff2_q;
  logic [WIDTH-1:0] ff3_q;
  logic [WIDTH-1:0] stable_q;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] stable_d;

  if (WIDTH < 1) begin : g_chk
    $error("gpcp_sync needs at least one bit");
  end

  // Only the second and third stages are compared
  assign agree = ~(ff2_q ^ ff3_q);
  assign stable_d = (agree & ff3_q) | (~agree & stable_q);
  assign o_stable = stable_q;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ff1_q <= '0;
      ff2_q <= '0;
      ff3_q <= '0;
      stable_q <= '0;
    end else begin
      ff1_q <= i_async;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      stable_q <= stable_d;
    end
  end
endmodule

// [verilog/gpcp_port.sv]
`timescale 1ns/1ps
// How it works
// R01 - Eight two-way pins, each with own direction bit and data bit.
// R02 - Direction bit one puts that pin driver in high impedance.
// R03 - Direction bit zero drives the pin from its output latch bit; the code leaves the pin undriven while its analog select bit is set.
// R04 - Output latch is its own register and reads back latched value.
// R05 - One active-low control bit enables all weak pull-ups when cleared.
// R06 - Pull-up is forced off on any pin set as output.
// R07 - Pull-ups are disabled after power-on reset.
// R08 - After reset lower five pins are analog reading zero, upper three digital.
// R09 - Alternate functions: interrupts, converter, serial port and PWM routed to pins.
// R10 - Change detection covers upper four pins, outputs excluded.
// R11 - Monitored inputs compared with value captured at last port read.
// R12 - Mismatches are ORed to set the port change flag.
// R13 - Port change flag can wake the device from sleep.
// R14 - Port read or write recaptures the compare value, except memory moves.
// R15 - Flag keeps setting while mismatch lasts; software ends mismatch, then clears.
// R16 - Software should not poll the port while change detection is used.
// R17 - Port read returns pin levels; port write updates the output latch.
module gpcp_port
  import gpcp_pkg::*;
#(
  parameter int PIN_W = GPCP_PIN_W
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire gpcp_acc_s i_acc,
  input wire logic i_flag_clr,
  input wire logic i_change_ie,
  input wire gpcp_alt_s i_alt,
  input wire logic [PIN_W-1:0] i_pin_in,
  output logic [PIN_W-1:0] o_pin_out,
  output logic [PIN_W-1:0] o_pin_oe,
  output logic [PIN_W-1:0] o_pin_pullup_en,
  output logic [PIN_W-1:0] o_port_pin_data,
  output logic [PIN_W-1:0] o_port_output_latch,
  output logic [PIN_W-1:0] o_pin_direction_mask,
  output logic [7:0] o_int_control_second,
  output logic [7:0] o_int_control_main,
  output logic [GPCP_ANALOG_W-1:0] o_analog_sel,
  output logic o_port_change_flag,
  output logic o_wake_req,
  output logic [2:0] o_ext_interrupt_in,
  output logic o_serial_rx,
  output logic [2:0] o_conv_analog_en
);

  if (PIN_W != GPCP_PIN_W) begin : g_chk
    $error("gpcp_port supports exactly eight pins");
  end

  logic [PIN_W-1:0] dir_q;
  logic [PIN_W-1:0] dir_d;
  logic [PIN_W-1:0] latch_q;
  logic [PIN_W-1:0] latch_d;
  logic [PIN_W-1:0] capt_q;
  logic [PIN_W-1:0] capt_d;
  logic pullup_disable_n_q;
  logic pullup_disable_n_d;
  logic [GPCP_ANALOG_W-1:0] analog_q;
  logic [GPCP_ANALOG_W-1:0] analog_d;
  logic flag_q;
  logic flag_d;
  logic [PIN_W-1:0] pin_out_q;
  logic [PIN_W-1:0] pin_out_d;
  logic [PIN_W-1:0] pin_oe_q;
  logic [PIN_W-1:0] pin_oe_d;
  logic [PIN_W-1:0] pullup_q;
  logic [PIN_W-1:0] pullup_d;
  logic [PIN_W-1:0] rdata_q;
  logic [PIN_W-1:0] rdata_d;
  logic [PIN_W-1:0] pin_sync;
  logic [PIN_W-1:0] pin_read;
  logic [PIN_W-1:0] analog_mask;
  logic [PIN_W-1:0] alt_en;
  logic [PIN_W-1:0] alt_val;
  logic [3:0] mismatch;
  logic capture;
  logic armed_q;
  logic armed_d;

  // Widens the analog select to a pin mask
  function automatic logic [7:0] gpcp_analog_mask(input logic [GPCP_ANALOG_W-1:0] sel);
    gpcp_analog_mask = {3'h0, sel};
  endfunction

  // Digital view of the pins, analog ones read low
  function automatic logic [7:0] gpcp_digital(input logic [7:0] lvl, input logic [7:0] amask);
    gpcp_digital = lvl & ~amask;
  endfunction

  // Pins cross from the board, so three stages first
  gpcp_sync #(
    .WIDTH(PIN_W)
  ) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_pin_in),
    .o_stable(pin_sync)
  );

  assign analog_mask = gpcp_analog_mask(analog_q);
  // R08 analog pins read zero
  assign pin_read = gpcp_digital(pin_sync, analog_mask);

  // R17 port write hits latch
  assign latch_d = (i_acc.wr_latch | i_acc.wr_port) ? i_acc.data : latch_q;
  // R01 per-pin direction
  assign dir_d = i_acc.wr_dir ? i_acc.data : dir_q;
  // R05 global pull-up control
  assign pullup_disable_n_d = i_acc.wr_ctl2 ? i_acc.data[GPCP_PULLUP_BIT] : pullup_disable_n_q;
  assign analog_d = i_acc.wr_analog ? i_acc.data[GPCP_ANALOG_W-1:0] : analog_q;

  // R14 any port access except memory move
  assign capture = (i_acc.rd_port | i_acc.wr_port) & ~i_acc.mem_move;
  // Compare value tracks pins until first access, no false change after reset
  assign armed_d = armed_q | capture;
  assign capt_d = (capture | ~armed_q) ? pin_read : capt_q;

  // R10 upper four inputs only
  // R11 against captured value
  assign mismatch = (pin_read[GPCP_MON_HI:GPCP_MON_LO] ^ capt_q[GPCP_MON_HI:GPCP_MON_LO])
    & dir_q[GPCP_MON_HI:GPCP_MON_LO] & {4{armed_q}};

  // R12 OR of mismatches
  // R15 set wins over clear, so a live mismatch keeps it
  assign flag_d = (|mismatch) | (flag_q & ~i_flag_clr);

  // R09 peripheral overrides on the pins
  always_comb begin
    alt_en = '0;
    alt_val = '0;
    alt_en[GPCP_SER_TX_PIN] = i_alt.ser_tx_en;
    alt_val[GPCP_SER_TX_PIN] = i_alt.ser_tx;
    alt_en[GPCP_PWM_PIN0] = i_alt.pwm_en[0];
    alt_val[GPCP_PWM_PIN0] = i_alt.pwm[0];
    alt_en[GPCP_PWM_PIN1] = i_alt.pwm_en[1];
    alt_val[GPCP_PWM_PIN1] = i_alt.pwm[1];
    alt_en[GPCP_PWM_PIN2] = i_alt.pwm_en[2];
    alt_val[GPCP_PWM_PIN2] = i_alt.pwm[2];
    alt_en[GPCP_PWM_PIN3] = i_alt.pwm_en[3];
    alt_val[GPCP_PWM_PIN3] = i_alt.pwm[3];
  end

  // R03 latch drives output pins
  assign pin_out_d = (alt_en & alt_val) | (~alt_en & latch_q);
  // R02 direction one releases the pin
  assign pin_oe_d = ~dir_q & ~analog_mask;
  // R06 pull-up only on inputs
  assign pullup_d = {PIN_W{~pullup_disable_n_q}} & dir_q;
  // R17 port reads pin levels
  assign rdata_d = pin_read;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dir_q <= GPCP_DIR_RST;
      latch_q <= GPCP_LATCH_RST;
      capt_q <= GPCP_CAPT_RST;
      // R07 pull-ups off at reset
      pullup_disable_n_q <= GPCP_PULLUP_DIS_RST;
      // R08 lower pins analog at reset
      analog_q <= GPCP_ANALOG_RST;
      flag_q <= GPCP_FLAG_RST;
      armed_q <= GPCP_ARMED_RST;
    end else begin
      dir_q <= dir_d;
      latch_q <= latch_d;
      capt_q <= capt_d;
      pullup_disable_n_q <= pullup_disable_n_d;
      analog_q <= analog_d;
      flag_q <= flag_d;
      armed_q <= armed_d;
    end
  end

  // Pin drive registered to keep glitches off the board
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
      pullup_q <= '0;
      rdata_q <= '0;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
      pullup_q <= pullup_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_pin_out = pin_out_q;
  assign o_pin_oe = pin_oe_q;
  assign o_pin_pullup_en = pullup_q;
  assign o_port_pin_data = rdata_q;
  // R04 latch reads back latch, not pins
  assign o_port_output_latch = latch_q;
  assign o_pin_direction_mask = dir_q;
  assign o_analog_sel = analog_q;
  assign o_int_control_second = {pullup_disable_n_q, 7'h00};
  assign o_int_control_main = {7'h00, flag_q};
  assign o_port_change_flag = flag_q;
  // R13 wake from sleep
  assign o_wake_req = flag_q & i_change_ie;
  // R09 inputs to interrupt, serial and converter units
  assign o_ext_interrupt_in = pin_read[2:0];
  assign o_serial_rx = pin_read[GPCP_SER_RX_PIN];
  assign o_conv_analog_en = {analog_mask[GPCP_CONV_PIN2], analog_mask[GPCP_CONV_PIN1], analog_mask[GPCP_CONV_PIN0]};

endmodule

// [verif/gpcp_port_sva.sv]
`timescale 1ns/1ps
module gpcp_port_sva
  import gpcp_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire gpcp_acc_s i_acc,
  input wire logic i_flag_clr,
  input wire logic i_change_ie,
  input wire logic [7:0] o_pin_oe,
  input wire logic [7:0] o_pin_pullup_en,
  input wire logic [7:0] o_port_output_latch,
  input wire logic [7:0] o_pin_direction_mask,
  input wire logic [7:0] o_int_control_second,
  input wire logic [4:0] o_analog_sel,
  input wire logic o_port_change_flag,
  input wire logic o_wake_req
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_kept;
    o_port_change_flag && !i_flag_clr;
  endsequence
  property p_lat; i_acc.wr_latch |=> o_port_output_latch == $past(i_acc.data); endproperty
  a_lat: assert property (p_lat) else $error("latch write lost");
  property p_prt; i_acc.wr_port |=> o_port_output_latch == $past(i_acc.data); endproperty
  a_prt: assert property (p_prt) else $error("port write lost");
  property p_dir; i_acc.wr_dir |=> o_pin_direction_mask == $past(i_acc.data); endproperty
  a_dir: assert property (p_dir) else $error("direction write lost");
  property p_ctl; i_acc.wr_ctl2 |=> o_int_control_second == {$past(i_acc.data[7]), 7'h0}; endproperty
  a_ctl: assert property (p_ctl) else $error("pullup control wrong");
  property p_oe; o_pin_oe == (~$past(o_pin_direction_mask) & ~{3'h0, $past(o_analog_sel)}); endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_pu; o_pin_pullup_en[7:5] == ($past(o_pin_direction_mask[7:5]) & {3{~$past(o_int_control_second[7])}});
  endproperty
  a_pu: assert property (p_pu) else $error("pullup wrong");
  property p_hold; s_kept |=> o_port_change_flag; endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");
  property p_wake; o_wake_req == (o_port_change_flag && i_change_ie); endproperty
  a_wake: assert property (p_wake) else $error("wake wrong");
endmodule
bind gpcp_port gpcp_port_sva u_sva(.i_core_clk, .i_sys_rst, .i_acc, .i_flag_clr, .i_change_ie, .o_pin_oe,
  .o_pin_pullup_en, .o_port_output_latch, .o_pin_direction_mask, .o_int_control_second, .o_analog_sel,
  .o_port_change_flag, .o_wake_req);

// [verif/gpcp_board.sv]
`timescale 1ns/1ps
module gpcp_board (
  input wire logic i_core_clk,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_pull,
  input wire logic [7:0] i_drv,
  input wire logic [7:0] i_drv_en,
  output logic [7:0] o_pin
);
  logic [7:0] float_q = 8'h55;
  // Floating pins wander, a stale level never passes
  always @(posedge i_core_clk) float_q <= ~float_q;
  assign o_pin = (i_oe & i_out) | (~i_oe & i_drv_en & i_drv) | (~i_oe & ~i_drv_en & (i_pull | float_q));
endmodule

// [verif/gpcp_port_tb.sv]
`timescale 1ns/1ps
module gpcp_port_tb;
  import gpcp_pkg::*;
  localparam logic [6:0] LAT = 7'h40, PRT = 7'h20, DIR = 7'h10, CT2 = 7'h08, ANA = 7'h04, RD = 7'h02, MM = 7'h01;
  logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_flag_clr = 1'b0, i_change_ie = 1'b0;
  gpcp_acc_s i_acc = '0;
  gpcp_alt_s i_alt = '0;
  logic [7:0] i_pin_in, o_pin_out, o_pin_oe, o_pin_pullup_en, o_port_pin_data, o_port_output_latch;
  logic [7:0] o_pin_direction_mask, o_int_control_second, o_int_control_main, drv = 8'hff, drv_en = 8'hff;
  logic [4:0] o_analog_sel;
  logic [2:0] o_ext_interrupt_in, o_conv_analog_en;
  logic o_port_change_flag, o_wake_req, o_serial_rx;
  int errors = 0, compares = 0;
  always #2.5 i_core_clk = ~i_core_clk;
  gpcp_port DUT(.i_core_clk, .i_sys_rst, .i_acc, .i_flag_clr, .i_change_ie, .i_alt, .i_pin_in, .o_pin_out,
    .o_pin_oe, .o_pin_pullup_en, .o_port_pin_data, .o_port_output_latch, .o_pin_direction_mask,
    .o_int_control_second, .o_int_control_main, .o_analog_sel, .o_port_change_flag, .o_wake_req,
    .o_ext_interrupt_in, .o_serial_rx, .o_conv_analog_en);
  gpcp_board u_board(.i_core_clk, .i_out(o_pin_out), .i_oe(o_pin_oe), .i_pull(o_pin_pullup_en), .i_drv(drv),
    .i_drv_en(drv_en), .o_pin(i_pin_in));
  task automatic op(input logic [6:0] s, input logic [7:0] d);
    @(posedge i_core_clk);
    i_acc <= {s, d};
    @(posedge i_core_clk);
    i_acc <= '0;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic clr;
    @(posedge i_core_clk);
    i_flag_clr <= 1'b1;
    @(posedge i_core_clk);
    i_flag_clr <= 1'b0;
    w(2);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge i_core_clk);
    errors++;
    summarize;
  end
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    w(8);
    chk(o_pin_direction_mask, 8'hff);
    chk(o_int_control_second, 8'h80);
    chk(o_pin_pullup_en, 8'h00);
    chk(o_port_pin_data, 8'he0);
    chk({3'h0, o_analog_sel}, 8'h1f);
    chk(o_pin_oe, 8'h00);
    chk({5'h0, o_conv_analog_en}, 8'h07);
    chk({7'h0, o_port_change_flag}, 8'h00);
    drv_en = 8'h00;
    op(ANA, 8'h00);
    op(DIR, 8'h00);
    op(LAT, 8'ha5);
    w(2);
    chk(o_port_output_latch, 8'ha5);
    chk(o_pin_out, 8'ha5);
    chk(o_pin_oe, 8'hff);
    op(PRT, 8'h3c);
    i_alt <= 10'h2ff;
    w(3);
    chk(o_port_output_latch, 8'h3c);
    chk(o_pin_out, 8'hfc);
    @(posedge i_core_clk);
    i_alt <= '0;
    op(DIR, 8'h0f);
    op(CT2, 8'h00);
    w(2);
    chk(o_pin_pullup_en, 8'h0f);
    drv = 8'h5a;
    drv_en = 8'hff;
    op(DIR, 8'hff);
    w(8);
    chk(o_port_pin_data, 8'h5a);
    chk({o_ext_interrupt_in, o_conv_analog_en, 1'b0, o_serial_rx}, 8'h41);
    op(RD, 8'h00);
    clr;
    chk(o_int_control_main, 8'h00);
    drv = 8'h7a;
    @(posedge i_core_clk);
    i_change_ie <= 1'b1;
    w(8);
    chk(o_int_control_main, 8'h01);
    chk({7'h0, o_wake_req}, 8'h01);
    op(RD | MM, 8'h00);
    clr;
    chk({7'h0, o_port_change_flag}, 8'h01);
    op(RD, 8'h00);
    clr;
    chk({7'h0, o_port_change_flag}, 8'h00);
    drv = 8'h78;
    op(DIR, 8'h0f);
    w(8);
    chk({7'h0, o_port_change_flag}, 8'h00);
    summarize;
  end
endmodule
